//--- src/rem_pkg.sv
package rem_pkg;

  localparam int unsigned MASK_W = 16;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned NUM_SRC = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FRAME_A = 8'h0c;
  localparam logic [7:0] IDX_FRAME_B = 8'h0d;
  localparam logic [7:0] IDX_MASK_LO = 8'h0e;
  localparam logic [7:0] IDX_MASK_HI = 8'h0f;

  localparam logic [7:0] RST_FRAME_A = 8'h40;
  localparam logic [7:0] RST_FRAME_B = 8'h01;
  localparam logic [7:0] RST_MASK_LO = 8'h00;
  localparam logic [7:0] RST_MASK_HI = 8'h00;

  // frame_handling_control_b fields
  localparam int unsigned FB_TX_SETS_LISTEN = 0;
  localparam int unsigned FB_TX_STARVE_IGN  = 1;
  localparam int unsigned FB_PENDING_FORCE  = 2;
  localparam logic [7:0]  FB_WRITABLE       = 8'h07;

  // mask bits touched by dedicated strobes
  localparam int unsigned BIT_RX_ON  = 15;
  localparam int unsigned BIT_TX_ON  = 14;
  localparam int unsigned BIT_MASK13 = 13;

  // change sources, 0 is the highest priority
  localparam int unsigned SRC_DATA_BUS = 0;
  localparam int unsigned SRC_RF_OFF   = 1;
  localparam int unsigned SRC_TX_ON    = 2;
  localparam int unsigned SRC_RX_ON    = 3;
  localparam int unsigned SRC_OR       = 4;
  localparam int unsigned SRC_AND      = 5;
  localparam int unsigned SRC_BIT_SET  = 6;
  localparam int unsigned SRC_BIT_CLR  = 7;

  typedef enum logic [3:0] {
    REM_SEL_NONE    = 4'h0,
    REM_SEL_FRAME_A = 4'h1,
    REM_SEL_FRAME_B = 4'h2,
    REM_SEL_MASK_LO = 4'h4,
    REM_SEL_MASK_HI = 4'h8
  } rem_sel_type;

endpackage

//--- src/rem_mask_resolve.sv
`timescale 1ns/100ps
module rem_mask_resolve (
  input  wire logic [rem_pkg::MASK_W-1:0]                  cur_mask,
  input  wire logic [rem_pkg::NUM_SRC*rem_pkg::MASK_W-1:0] req_en,
  input  wire logic [rem_pkg::NUM_SRC*rem_pkg::MASK_W-1:0] req_val,
  output logic      [rem_pkg::MASK_W-1:0]                  next_mask
);
  import rem_pkg::*;

  genvar b;
  generate
    for (b = 0; b < MASK_W; b++) begin : g_bit
      // per bit: highest-priority requester touching this bit wins
      always_comb begin
        next_mask[b] = cur_mask[b];
        for (int s = NUM_SRC - 1; s >= 0; s--) begin
          if (req_en[s*MASK_W + b]) begin
            next_mask[b] = req_val[s*MASK_W + b];
          end
        end
      end
    end
  endgenerate

endmodule

//--- src/rem_receive_enable_mask_control.sv
`timescale 1ns/100ps
// Functional notes
// - frame_b bit 2 high forces ack pending bit to one, else fsm decides
// - underflow-ignore low: transmit underflow aborts the ongoing transmission
// - underflow-ignore high: underflow ignored, length field sets byte count
// - frame_b bit 0 (reset 1) lets transmit-on strobe set mask bit 14
// - non-zero mask enables receiver when idle and after transmissions
// - receive-on strobe sets mask bit 15 only
// - radio-off strobe clears the whole mask
// - mask-and instruction ands the mask with its 16-bit parameter
// - mask-or instruction ors the mask with its 16-bit parameter
// - mask is register writable; bit set/clear reach any of 16 bits
// - dedicated strobes set and clear mask bit 13
// - simultaneous requests on different bits are all applied
// - data bus changes beat every other source
// - strobe priority: off, tx-on, rx-on, or, and, bit13 set, bit13 clear
// - mask held as two bytes reset to zero, low byte at lower address
module rem_receive_enable_mask_control (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [7:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       radio_off_strobe,
  input  wire logic                       transmit_on_strobe,
  input  wire logic                       receive_on_strobe,
  input  wire logic                       mask_bit13_set_strobe,
  input  wire logic                       mask_bit13_clear_strobe,
  input  wire logic                       mask_and_instruction,
  input  wire logic                       mask_or_instruction,
  input  wire logic [rem_pkg::MASK_W-1:0] mask_parameter,
  input  wire logic                       bit_set_instruction,
  input  wire logic                       bit_clear_instruction,
  input  wire logic [3:0]                 bit_index,
  input  wire logic                       memory_write_instruction,
  input  wire logic [7:0]                 mem_wr_index,
  input  wire logic [7:0]                 mem_wr_data,
  input  wire logic                       fsm_pending_bit,
  input  wire logic                       tx_underflow_event,
  output logic                            receiver_enable,
  output logic                            ack_pending_bit,
  output logic                            tx_abort,
  output logic                            tx_length_mode,
  output logic      [rem_pkg::MASK_W-1:0] receive_on_mask
);
  import rem_pkg::*;

  function automatic rem_sel_type decode_index(input logic [7:0] idx);
    rem_sel_type sel;
    sel = REM_SEL_NONE;
    if (idx == IDX_FRAME_A) begin
      sel = REM_SEL_FRAME_A;
    end else if (idx == IDX_FRAME_B) begin
      sel = REM_SEL_FRAME_B;
    end else if (idx == IDX_MASK_LO) begin
      sel = REM_SEL_MASK_LO;
    end else if (idx == IDX_MASK_HI) begin
      sel = REM_SEL_MASK_HI;
    end
    return sel;
  endfunction

  logic [REG_W-1:0]          frame_a_q;
  logic [REG_W-1:0]          frame_b_q;
  logic [MASK_W-1:0]         mask_q;
  logic [MASK_W-1:0]         mask_d;
  logic                      wait_q;
  logic [31:0]               rdata_q;
  logic                      rx_en_q;
  logic                      ack_pend_q;
  logic                      tx_abort_q;
  logic                      tx_len_q;

  logic                      req;
  logic                      accept_wr;
  logic                      word_ok;
  rem_sel_type               bus_sel;
  rem_sel_type               mem_sel;
  logic                      bus_wr_lane;
  logic [7:0]                bus_wdata;

  logic [MASK_W-1:0]         bus_en;
  logic [MASK_W-1:0]         bus_val;
  logic [NUM_SRC*MASK_W-1:0] req_en;
  logic [NUM_SRC*MASK_W-1:0] req_val;

  assign req         = avs_read | avs_write;
  assign word_ok     = (avs_address[1:0] == 2'b00);
  assign bus_sel     = word_ok ? decode_index({2'b00, avs_address[7:2]}) : REM_SEL_NONE;
  assign mem_sel     = decode_index(mem_wr_index);
  assign accept_wr   = avs_write & ~wait_q;
  assign bus_wr_lane = accept_wr & avs_byteenable[0];
  assign bus_wdata   = avs_writedata[7:0];

  // one wait cycle, then the request is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & wait_q) begin
      unique case (bus_sel)
        REM_SEL_FRAME_A: rdata_q <= {24'h00_0000, frame_a_q};
        // reserved frame_b bits read zero
        // reserved zero
        REM_SEL_FRAME_B: rdata_q <= {24'h00_0000, frame_b_q & FB_WRITABLE};
        REM_SEL_MASK_LO: rdata_q <= {24'h00_0000, mask_q[7:0]};
        REM_SEL_MASK_HI: rdata_q <= {24'h00_0000, mask_q[15:8]};
        REM_SEL_NONE:    rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      frame_a_q <= RST_FRAME_A;
    end else if (bus_wr_lane && bus_sel == REM_SEL_FRAME_A) begin
      frame_a_q <= bus_wdata;
    end else if (memory_write_instruction && mem_sel == REM_SEL_FRAME_A) begin
      frame_a_q <= mem_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      frame_b_q <= RST_FRAME_B;
    end else if (bus_wr_lane && bus_sel == REM_SEL_FRAME_B) begin
      frame_b_q <= bus_wdata & FB_WRITABLE;
    end else if (memory_write_instruction && mem_sel == REM_SEL_FRAME_B) begin
      frame_b_q <= mem_wr_data & FB_WRITABLE;
    end
  end

  // data bus requests: register write, memory write, bit set and clear
  always_comb begin
    bus_en  = '0;
    bus_val = '0;
    if (bit_set_instruction) begin
      bus_en[bit_index]  = 1'b1;
      bus_val[bit_index] = 1'b1;
    end
    if (bit_clear_instruction) begin
      bus_en[bit_index]  = 1'b1;
      bus_val[bit_index] = 1'b0;
    end
    if (memory_write_instruction && mem_sel == REM_SEL_MASK_LO) begin
      bus_en[7:0]  = 8'hff;
      bus_val[7:0] = mem_wr_data;
    end
    if (memory_write_instruction && mem_sel == REM_SEL_MASK_HI) begin
      bus_en[15:8]  = 8'hff;
      bus_val[15:8] = mem_wr_data;
    end
    if (bus_wr_lane && bus_sel == REM_SEL_MASK_LO) begin
      bus_en[7:0]  = 8'hff;
      bus_val[7:0] = bus_wdata;
    end
    if (bus_wr_lane && bus_sel == REM_SEL_MASK_HI) begin
      bus_en[15:8]  = 8'hff;
      bus_val[15:8] = bus_wdata;
    end
  end

  always_comb begin
    req_en  = '0;
    req_val = '0;
    req_en[SRC_DATA_BUS*MASK_W +: MASK_W]  = bus_en;
    req_val[SRC_DATA_BUS*MASK_W +: MASK_W] = bus_val;
    if (radio_off_strobe) begin
      req_en[SRC_RF_OFF*MASK_W +: MASK_W] = '1;
    end
    if (transmit_on_strobe && frame_b_q[FB_TX_SETS_LISTEN]) begin
      req_en[SRC_TX_ON*MASK_W + BIT_TX_ON]  = 1'b1;
      req_val[SRC_TX_ON*MASK_W + BIT_TX_ON] = 1'b1;
    end
    if (receive_on_strobe) begin
      req_en[SRC_RX_ON*MASK_W + BIT_RX_ON]  = 1'b1;
      req_val[SRC_RX_ON*MASK_W + BIT_RX_ON] = 1'b1;
    end
    if (mask_or_instruction) begin
      req_en[SRC_OR*MASK_W +: MASK_W]  = mask_parameter;
      req_val[SRC_OR*MASK_W +: MASK_W] = '1;
    end
    if (mask_and_instruction) begin
      req_en[SRC_AND*MASK_W +: MASK_W] = ~mask_parameter;
    end
    if (mask_bit13_set_strobe) begin
      req_en[SRC_BIT_SET*MASK_W + BIT_MASK13]  = 1'b1;
      req_val[SRC_BIT_SET*MASK_W + BIT_MASK13] = 1'b1;
    end
    if (mask_bit13_clear_strobe) begin
      req_en[SRC_BIT_CLR*MASK_W + BIT_MASK13] = 1'b1;
    end
  end

  rem_mask_resolve u_resolve (
    .cur_mask  (mask_q),
    .req_en    (req_en),
    .req_val   (req_val),
    .next_mask (mask_d)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q <= {RST_MASK_HI, RST_MASK_LO};
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_en_q <= 1'b0;
    end else begin
      rx_en_q <= (mask_d != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_pend_q <= 1'b0;
    end else begin
      ack_pend_q <= frame_b_q[FB_PENDING_FORCE] | fsm_pending_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_abort_q <= 1'b0;
    end else begin
      tx_abort_q <= tx_underflow_event & ~frame_b_q[FB_TX_STARVE_IGN];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_len_q <= 1'b0;
    end else begin
      tx_len_q <= frame_b_q[FB_TX_STARVE_IGN];
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign receiver_enable = rx_en_q;
  assign ack_pending_bit = ack_pend_q;
  assign tx_abort        = tx_abort_q;
  assign tx_length_mode  = tx_len_q;
  assign receive_on_mask = mask_q;

endmodule

//--- dv/rem_chk_asserts.sv
`timescale 1ns/100ps
module rem_chk (
  input wire logic                       clk,
  input wire logic                       srst,
  input wire logic                       avs_write,
  input wire logic                       radio_off_strobe,
  input wire logic                       receive_on_strobe,
  input wire logic                       transmit_on_strobe,
  input wire logic                       mask_bit13_set_strobe,
  input wire logic                       mask_bit13_clear_strobe,
  input wire logic                       mask_and_instruction,
  input wire logic                       mask_or_instruction,
  input wire logic                       bit_set_instruction,
  input wire logic                       bit_clear_instruction,
  input wire logic                       memory_write_instruction,
  input wire logic                       fsm_pending_bit,
  input wire logic                       tx_underflow_event,
  input wire logic                       receiver_enable,
  input wire logic                       ack_pending_bit,
  input wire logic                       tx_abort,
  input wire logic                       tx_length_mode,
  input wire logic [rem_pkg::MASK_W-1:0] mask_parameter,
  input wire logic [rem_pkg::MASK_W-1:0] receive_on_mask
);
  import rem_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic bus, oth;
  // any data bus source, and every strobe except the and instruction
  assign bus = avs_write | bit_set_instruction | bit_clear_instruction | memory_write_instruction;
  assign oth = radio_off_strobe | transmit_on_strobe | receive_on_strobe | mask_or_instruction
    | mask_bit13_set_strobe | mask_bit13_clear_strobe;
  chk_off_clears: assert property (radio_off_strobe && !bus |=> receive_on_mask == '0)
    else $error("off strobe left bits set");
  chk_rx_on_bit: assert property (receive_on_strobe && !radio_off_strobe && !bus
    |=> receive_on_mask[BIT_RX_ON])
    else $error("receive-on strobe did not set bit 15");
  chk_bit13_set: assert property (mask_bit13_set_strobe && !radio_off_strobe && !bus
    && !mask_and_instruction |=> receive_on_mask[BIT_MASK13])
    else $error("bit 13 strobe did not set bit 13");
  chk_or_sets: assert property (mask_or_instruction && !radio_off_strobe && !bus
    |=> (receive_on_mask & $past(mask_parameter)) == $past(mask_parameter))
    else $error("or instruction missed bits");
  chk_and_result: assert property (mask_and_instruction && !bus && !oth
    |=> receive_on_mask == ($past(receive_on_mask) & $past(mask_parameter)))
    else $error("and instruction result wrong");
  chk_mask_holds: assert property (!bus && !oth && !mask_and_instruction
    |=> $stable(receive_on_mask))
    else $error("mask changed without a source");
  chk_rx_enable: assert property (receiver_enable == (receive_on_mask != '0))
    else $error("receiver enable does not follow mask");
  chk_pending_fsm: assert property (fsm_pending_bit |=> ack_pending_bit)
    else $error("pending bit lost fsm request");
  chk_underflow_abort: assert property (tx_underflow_event |=> tx_abort == !tx_length_mode)
    else $error("underflow abort wrong");
  cover property (radio_off_strobe && receive_on_strobe);
  cover property (bit_set_instruction && radio_off_strobe);
  cover property (tx_abort);
endmodule
bind rem_receive_enable_mask_control rem_chk i_chk (.*);

//--- dv/rem_host.sv
`timescale 1ns/100ps
module rem_host (
  input  wire logic        clk,
  output logic      [9:0]  st,
  output logic      [15:0] prm
);
  initial begin
    st = '0;
    prm = '0;
  end
  // one-cycle pulse; several sources may share it
  task automatic fire(input logic [9:0] s, input logic [15:0] p);
    @(posedge clk);
    st <= s;
    prm <= p;
    @(posedge clk);
    st <= '0;
  endtask
endmodule

//--- dv/rem_receive_enable_mask_control_tb.sv
`timescale 1ns/100ps
module rem_receive_enable_mask_control_tb;
  import rem_pkg::*;
  localparam logic [9:0] OFF = 10'h001, TX = 10'h002, RX = 10'h004, ORI = 10'h008;
  localparam logic [9:0] ANDI = 10'h010, S13 = 10'h020, C13 = 10'h040, BS = 10'h080;
  localparam logic [9:0] BC = 10'h100, MW = 10'h200;
  logic        clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, und = 1'b0, fsm = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [9:0]  st;
  logic [15:0] prm, mask;
  logic        wait_rq, ren, ackp, abrt, lenm;
  int          num_errors = 0, checked = 0;
  logic [31:0] rst_v [5] = '{32'h40, 32'h01, 32'h00, 32'h00, 32'h00};
  always #50 clk = ~clk;
  rem_host i_host (.clk(clk), .st(st), .prm(prm));
  rem_receive_enable_mask_control i_dut (.clk(clk), .srst(srst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h1),
    .avs_readdata(rdat), .avs_waitrequest(wait_rq), .radio_off_strobe(st[0]),
    .transmit_on_strobe(st[1]), .receive_on_strobe(st[2]), .mask_or_instruction(st[3]),
    .mask_and_instruction(st[4]), .mask_bit13_set_strobe(st[5]),
    .mask_bit13_clear_strobe(st[6]), .bit_set_instruction(st[7]),
    .bit_clear_instruction(st[8]), .memory_write_instruction(st[9]), .mask_parameter(prm),
    .bit_index(prm[3:0]), .mem_wr_index(prm[15:8]), .mem_wr_data(prm[7:0]),
    .fsm_pending_bit(fsm), .tx_underflow_event(und), .receiver_enable(ren),
    .ack_pending_bit(ackp), .tx_abort(abrt), .tx_length_mode(lenm), .receive_on_mask(mask));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkm(input logic [15:0] e);
    @(negedge clk);
    chk(mask, e);
  endtask
  // hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wait_rq !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic uf(input logic e);
    @(posedge clk);
    und <= 1'b1;
    @(posedge clk);
    und <= 1'b0;
    @(negedge clk);
    chk(abrt, e);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'h30 + 8'(4 * i), 8'h00);
      chk(q, rst_v[i]);
    end
    $display("reset test done");
    bus(1'b1, 8'h38, 8'ha5);
    bus(1'b1, 8'h3c, 8'h5a);
    bus(1'b1, 8'h40, 8'hff);
    chkm(16'h5aa5);
    chk(ren, 1);
    bus(1'b0, 8'h3c, 8'h00);
    chk(q, 32'h5a);
    bus(1'b1, 8'h34, 8'hff);
    bus(1'b0, 8'h34, 8'h00);
    chk(q, 32'h07);
    $display("register test done");
    host(OFF, 16'h0, 16'h0000);
    chk(ren, 0);
    host(RX, 16'h0, 16'h8000);
    host(TX, 16'h0, 16'hc000);
    bus(1'b1, 8'h34, 8'h06);
    host(BC, 16'h000e, 16'h8000);
    host(TX | RX, 16'h0, 16'h8000);
    chk(ackp, 1);
    host(ORI, 16'h00f0, 16'h80f0);
    host(ANDI, 16'hff3f, 16'h8030);
    host(S13, 16'h0, 16'ha030);
    host(C13, 16'h0, 16'h8030);
    host(BS, 16'h0003, 16'h8038);
    host(BC, 16'h000f, 16'h0038);
    host(MW, 16'h0f3c, 16'h3c38);
    $display("source test done");
    host(OFF | RX, 16'h0, 16'h0000);
    host(RX | ORI, 16'h0001, 16'h8001);
    host(S13 | C13, 16'h0, 16'ha001);
    host(ORI | ANDI, 16'h0001, 16'h0001);
    host(BS | OFF, 16'h000f, 16'h8000);
    $display("priority test done");
    uf(1'b0);
    chk(lenm, 1);
    bus(1'b1, 8'h34, 8'h00);
    uf(1'b1);
    chk(ackp, 0);
    @(posedge clk);
    fsm <= 1'b1;
    repeat (2) @(negedge clk);
    chk(ackp, 1);
    $display("frame control test done");
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chkm(16'h0000);
    bus(1'b0, 8'h34, 8'h00);
    chk(q, 32'h01);
    host(TX, 16'h0, 16'h4000);
    $display("second reset test done");
    test_done();
  end
  task automatic host(input logic [9:0] s, input logic [15:0] p, input logic [15:0] e);
    i_host.fire(s, p);
    chkm(e);
  endtask
endmodule
